// [rtl/tcwl_pkg.sv]
// Constants for the timer configuration write lock block.
// Assumes a byte-addressed register port with 16-bit registers in 32-bit words.
package tcwl_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W  = 16;

    // Register byte offsets
    localparam logic [7:0] OFS_TIMER_CONTROL_TWO       = 8'h04;
    localparam logic [7:0] OFS_CHANNEL_MODE_ONE        = 8'h18;
    localparam logic [7:0] OFS_CHANNEL_MODE_TWO        = 8'h1c;
    localparam logic [7:0] OFS_CHANNEL_ENABLE_REGISTER = 8'h20;
    localparam logic [7:0] OFS_BREAK_DEADTIME_CONTROL  = 8'h44;

    // Reset values
    localparam logic [15:0] RST_TIMER_CONTROL_TWO       = 16'h0000;
    localparam logic [15:0] RST_CHANNEL_MODE            = 16'h0000;
    localparam logic [15:0] RST_CHANNEL_ENABLE_REGISTER = 16'h0000;
    localparam logic [15:0] RST_BREAK_DEADTIME_CONTROL  = 16'h0000;

    // Field positions in break_deadtime_control
    localparam int BDT_PROTECT_LEVEL_LSB         = 8;
    localparam int BDT_IDLE_MODE_OFFSTATE_BIT    = 10;
    localparam int BDT_RUN_MODE_OFFSTATE_BIT     = 11;
    localparam int BDT_MAIN_OUTPUT_ENABLE_BIT    = 15;
    // Field positions in timer_control_two and channel_enable_register
    localparam int CTRL2_OUTPUT_IDLE_STATE_LSB   = 8;
    localparam int CCEN_STRIDE                   = 4;

    // Bits guarded at each protect level
    localparam logic [15:0] BDT_LOCK_FIELD_MASK  = 16'h0300;
    localparam logic [15:0] BDT_LEVEL1_MASK      = 16'h70ff;
    localparam logic [15:0] BDT_LEVEL2_MASK      = 16'h0c00;
    localparam logic [15:0] CTRL2_LEVEL1_MASK    = 16'h7f00;
    localparam logic [15:0] CCEN_LEVEL2_MASK     = 16'h2aaa;
    localparam logic [15:0] CCM_LEVEL3_MASK      = 16'h7878;

    localparam logic [1:0] LEVEL_OFF = 2'h0;
    localparam logic [1:0] LEVEL_ONE = 2'h1;
    localparam logic [1:0] LEVEL_TWO = 2'h2;
    localparam logic [1:0] LEVEL_THR = 2'h3;

endpackage

// [rtl/tcwl_prot_reg.sv]
// One 16-bit register whose write is gated bit by bit by a lock mask.
// Assumes the caller forms the mask from the current protect level.
`timescale 1ns/100ps
module tcwl_prot_reg
    import tcwl_pkg::*;
#(
    parameter int          WIDTH = REG_W,
    parameter logic [15:0] RESET = 16'h0000
) (
    // Clock and reset
    input  wire logic             ref_clk_i,
    input  wire logic             rst_i,
    // Write side
    input  wire logic             wr_i,
    input  wire logic [WIDTH-1:0] wdata_i,
    input  wire logic [WIDTH-1:0] lock_mask_i,
    // Stored value
    output logic      [WIDTH-1:0] q_o
);

    logic [WIDTH-1:0] q_reg;
    logic [WIDTH-1:0] q_next;

    always_comb begin
        q_next = (q_reg & lock_mask_i) | (wdata_i & ~lock_mask_i);
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            q_reg <= RESET[WIDTH-1:0];
        end else if (wr_i) begin
            q_reg <= q_next;
        end
    end

    assign q_o = q_reg;

    chk_locked_bits_hold: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        wr_i |=> ((q_reg & $past(lock_mask_i)) == ($past(q_reg) & $past(lock_mask_i))))
        else $error("locked bits changed on write");

    chk_free_bits_load: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        wr_i |=> ((q_reg & ~$past(lock_mask_i)) == ($past(wdata_i) & ~$past(lock_mask_i))))
        else $error("unlocked bits did not take write data");

endmodule

// [rtl/tcwl_top.sv]
// Write-protection bank for the timer's safety-critical configuration.
// Assumes a same-clock register master: one-cycle strobes, read data next cycle.
`timescale 1ns/100ps
module tcwl_top
    import tcwl_pkg::*;
#(
    parameter int NUM_CHANNELS = 4
) (
    // Clock and reset
    input  wire logic              ref_clk_i,
    input  wire logic              rst_i,
    // Register port
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic      [DATA_W-1:0] rdata_o,
    // Configuration to the timer datapath
    output logic      [7:0]        dead_time_setting_o,
    output logic      [1:0]        protect_level_o,
    output logic                   main_output_enable_o,
    output logic [NUM_CHANNELS-1:0] channel_output_enable_o,
    output logic [NUM_CHANNELS-1:0] chan_offstate_drive_o,
    output logic [NUM_CHANNELS-1:0] chan_idle_level_o,
    output logic [REG_W-1:0]       break_deadtime_control_o,
    output logic [REG_W-1:0]       timer_control_two_o,
    output logic [REG_W-1:0]       channel_enable_register_o,
    output logic [REG_W-1:0]       channel_mode_one_o,
    output logic [REG_W-1:0]       channel_mode_two_o
);

    logic [REG_W-1:0]  bdt_q;
    logic [REG_W-1:0]  ctrl2_q;
    logic [REG_W-1:0]  ccen_q;
    logic [REG_W-1:0]  ccm1_q;
    logic [REG_W-1:0]  ccm2_q;
    logic [REG_W-1:0]  bdt_mask;
    logic [REG_W-1:0]  ctrl2_mask;
    logic [REG_W-1:0]  ccen_mask;
    logic [REG_W-1:0]  ccm_mask;
    logic [1:0]        protect_level;
    logic              level_written_reg;
    logic              wr_bdt;
    logic              wr_ctrl2;
    logic              wr_ccen;
    logic              wr_ccm1;
    logic              wr_ccm2;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;
    logic              main_out_en;
    logic              idle_offstate;
    logic              run_offstate;

    // Address decode
    assign wr_bdt   = wr_i && (addr_i == OFS_BREAK_DEADTIME_CONTROL);
    assign wr_ctrl2 = wr_i && (addr_i == OFS_TIMER_CONTROL_TWO);
    assign wr_ccen  = wr_i && (addr_i == OFS_CHANNEL_ENABLE_REGISTER);
    assign wr_ccm1  = wr_i && (addr_i == OFS_CHANNEL_MODE_ONE);
    assign wr_ccm2  = wr_i && (addr_i == OFS_CHANNEL_MODE_TWO);

    assign protect_level = bdt_q[BDT_PROTECT_LEVEL_LSB +: 2];

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            level_written_reg <= 1'b0;
        end else if (wr_bdt) begin
            level_written_reg <= 1'b1;
        end
    end

    always_comb begin
        bdt_mask   = level_written_reg ? BDT_LOCK_FIELD_MASK : 16'h0000;
        ctrl2_mask = 16'h0000;
        ccen_mask  = 16'h0000;
        ccm_mask   = 16'h0000;
        if (protect_level != LEVEL_OFF) begin
            bdt_mask   = bdt_mask | BDT_LEVEL1_MASK;
            ctrl2_mask = CTRL2_LEVEL1_MASK;
        end
        if (protect_level == LEVEL_TWO || protect_level == LEVEL_THR) begin
            bdt_mask  = bdt_mask | BDT_LEVEL2_MASK;
            ccen_mask = CCEN_LEVEL2_MASK;
        end
        if (protect_level == LEVEL_THR) begin
            ccm_mask = CCM_LEVEL3_MASK;
        end
    end

    tcwl_prot_reg #(
        .WIDTH (REG_W),
        .RESET (RST_BREAK_DEADTIME_CONTROL)
    ) u_bdt (
        .ref_clk_i   (ref_clk_i),
        .rst_i       (rst_i),
        .wr_i        (wr_bdt),
        .wdata_i     (wdata_i[REG_W-1:0]),
        .lock_mask_i (bdt_mask),
        .q_o         (bdt_q)
    );

    tcwl_prot_reg #(
        .WIDTH (REG_W),
        .RESET (RST_TIMER_CONTROL_TWO)
    ) u_ctrl2 (
        .ref_clk_i   (ref_clk_i),
        .rst_i       (rst_i),
        .wr_i        (wr_ctrl2),
        .wdata_i     (wdata_i[REG_W-1:0]),
        .lock_mask_i (ctrl2_mask),
        .q_o         (ctrl2_q)
    );

    tcwl_prot_reg #(
        .WIDTH (REG_W),
        .RESET (RST_CHANNEL_ENABLE_REGISTER)
    ) u_ccen (
        .ref_clk_i   (ref_clk_i),
        .rst_i       (rst_i),
        .wr_i        (wr_ccen),
        .wdata_i     (wdata_i[REG_W-1:0]),
        .lock_mask_i (ccen_mask),
        .q_o         (ccen_q)
    );

    tcwl_prot_reg #(
        .WIDTH (REG_W),
        .RESET (RST_CHANNEL_MODE)
    ) u_ccm1 (
        .ref_clk_i   (ref_clk_i),
        .rst_i       (rst_i),
        .wr_i        (wr_ccm1),
        .wdata_i     (wdata_i[REG_W-1:0]),
        .lock_mask_i (ccm_mask),
        .q_o         (ccm1_q)
    );

    tcwl_prot_reg #(
        .WIDTH (REG_W),
        .RESET (RST_CHANNEL_MODE)
    ) u_ccm2 (
        .ref_clk_i   (ref_clk_i),
        .rst_i       (rst_i),
        .wr_i        (wr_ccm2),
        .wdata_i     (wdata_i[REG_W-1:0]),
        .lock_mask_i (ccm_mask),
        .q_o         (ccm2_q)
    );

    // Read mux; unmapped offsets read as zero
    always_comb begin
        rdata_next = '0;
        unique case (addr_i)
            OFS_BREAK_DEADTIME_CONTROL:  rdata_next[REG_W-1:0] = bdt_q;
            OFS_TIMER_CONTROL_TWO:       rdata_next[REG_W-1:0] = ctrl2_q;
            OFS_CHANNEL_ENABLE_REGISTER: rdata_next[REG_W-1:0] = ccen_q;
            OFS_CHANNEL_MODE_ONE:        rdata_next[REG_W-1:0] = ccm1_q;
            OFS_CHANNEL_MODE_TWO:        rdata_next[REG_W-1:0] = ccm2_q;
            default:                     rdata_next = '0;
        endcase
    end

    // Data stands only in the cycle after the strobe
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            rdata_reg <= '0;
        end else if (rd_i) begin
            rdata_reg <= rdata_next;
        end else begin
            rdata_reg <= '0;
        end
    end

    assign rdata_o = rdata_reg;

    assign main_out_en   = bdt_q[BDT_MAIN_OUTPUT_ENABLE_BIT];
    assign idle_offstate = bdt_q[BDT_IDLE_MODE_OFFSTATE_BIT];
    assign run_offstate  = bdt_q[BDT_RUN_MODE_OFFSTATE_BIT];

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CHANNELS; ch++) begin : g_chan
            assign channel_output_enable_o[ch] = ccen_q[ch*CCEN_STRIDE];
            assign chan_offstate_drive_o[ch] = main_out_en
                ? (!ccen_q[ch*CCEN_STRIDE] && run_offstate) : idle_offstate;
            assign chan_idle_level_o[ch]     = ctrl2_q[CTRL2_OUTPUT_IDLE_STATE_LSB + 2*ch];
        end
    endgenerate

    assign dead_time_setting_o       = bdt_q[7:0];
    assign protect_level_o           = protect_level;
    assign main_output_enable_o      = main_out_en;
    assign break_deadtime_control_o  = bdt_q;
    assign timer_control_two_o       = ctrl2_q;
    assign channel_enable_register_o = ccen_q;
    assign channel_mode_one_o        = ccm1_q;
    assign channel_mode_two_o        = ccm2_q;

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);

    chk_level_first_write: assert property (
        (wr_bdt && !level_written_reg) |=> (protect_level == $past(wdata_i[9:8])))
        else $error("first level write not taken");

    chk_level_held_later: assert property (
        (wr_bdt && level_written_reg) |=> $stable(protect_level))
        else $error("protect level changed after first write");

    chk_level0_all_free: assert property (
        (wr_ccm1 && protect_level == LEVEL_OFF && level_written_reg)
        |=> (ccm1_q == $past(wdata_i[15:0])))
        else $error("level 00 blocked a write");

    chk_level1_deadtime: assert property (
        (wr_bdt && protect_level != LEVEL_OFF) |=> $stable(dead_time_setting_o))
        else $error("dead time changed while locked");

    chk_level1_idle_bits: assert property (
        (wr_ctrl2 && protect_level != LEVEL_OFF) |=> $stable(ctrl2_q[14:8]))
        else $error("idle state bits changed while locked");

    chk_level2_polarity: assert property (
        (wr_ccen && protect_level[1]) |=> ((ccen_q & CCEN_LEVEL2_MASK)
            == ($past(ccen_q) & CCEN_LEVEL2_MASK)))
        else $error("polarity bits changed at level two or three");

    chk_level2_enables_free: assert property (
        (wr_ccen && protect_level[1]) |=> (channel_output_enable_o
            == {$past(wdata_i[12]), $past(wdata_i[8]), $past(wdata_i[4]), $past(wdata_i[0])}))
        else $error("channel enables blocked by lock");

    chk_level3_mode: assert property (
        (wr_ccm2 && protect_level == LEVEL_THR) |=> $stable(ccm2_q[14:11]) ##0 $stable(ccm2_q[6:3]))
        else $error("compare mode changed at level three");

    chk_level2_mode_free: assert property (
        (wr_ccm1 && protect_level == LEVEL_TWO) |=> (ccm1_q == $past(wdata_i[15:0])))
        else $error("compare mode blocked below level three");

    chk_main_output_enable_writable: assert property (
        wr_bdt |=> (main_output_enable_o == $past(wdata_i[15])))
        else $error("main output enable not written");

    chk_level1_break_bits: assert property (
        (wr_bdt && protect_level != LEVEL_OFF) |=> $stable(bdt_q[14:12]))
        else $error("break settings changed while locked");

    chk_level2_offstate: assert property (
        (wr_bdt && protect_level[1]) |=> $stable(bdt_q[11:10]))
        else $error("off-state selects changed at level two or three");

    chk_level1_offstate_free: assert property (
        (wr_bdt && protect_level == LEVEL_ONE) |=> (bdt_q[11:10] == $past(wdata_i[11:10])))
        else $error("off-state selects blocked at level one");

    chk_level3_ccm1: assert property (
        (wr_ccm1 && protect_level == LEVEL_THR) |=> $stable(ccm1_q & CCM_LEVEL3_MASK))
        else $error("compare mode or preload changed at level three");

    chk_level0_ctrl2_free: assert property (
        (wr_ctrl2 && protect_level == LEVEL_OFF) |=> (ctrl2_q == $past(wdata_i[15:0])))
        else $error("level 00 blocked a control two write");

    chk_read_idle_zero: assert property (
        !$past(rd_i) |-> (rdata_o == '0))
        else $error("read data present without a read");

    chk_idle_offstate: assert property (
        !main_out_en |-> (chan_offstate_drive_o == {NUM_CHANNELS{idle_offstate}}))
        else $error("idle mode off-state wrong");

    chk_run_offstate: assert property (
        main_out_en |-> (chan_offstate_drive_o
            == (~channel_output_enable_o & {NUM_CHANNELS{run_offstate}})))
        else $error("run mode off-state wrong");

    chk_read_timing: assert property (
        (rd_i && addr_i == OFS_BREAK_DEADTIME_CONTROL) |=> (rdata_o[15:0] == bdt_q) ##1 (rdata_o == '0 || $past(rd_i)))
        else $error("read data timing wrong");

    cov_level_three: cover property (wr_bdt && !level_written_reg && wdata_i[9:8] == LEVEL_THR);
    cov_blocked_ccm: cover property (wr_ccm1 && protect_level == LEVEL_THR);
    cov_relock_try: cover property (wr_bdt && level_written_reg && protect_level == LEVEL_ONE);
    cov_idle_mode: cover property (!main_out_en && idle_offstate);
    cov_level_two: cover property (wr_bdt && !level_written_reg && wdata_i[9:8] == LEVEL_TWO);

endmodule

// [testbench/test_tcwl_top.sv]
// Self-checking bench for the timer configuration write lock bank.
// Assumes one 125 MHz clock and the one-cycle strobe register port.
`timescale 1ns/100ps
module test_tcwl_top
    import tcwl_pkg::*;
;
    logic              ref_clk_i;
    logic              rst_i;
    logic [ADDR_W-1:0] addr_i;
    logic [DATA_W-1:0] wdata_i;
    logic              wr_i;
    logic              rd_i;
    logic [DATA_W-1:0] rdata_o;
    logic [7:0]        dead_time;
    logic [1:0]        lvl_o;
    logic              main_en;
    logic [3:0]        chan_en;
    logic [3:0]        offdrv;
    logic [3:0]        idle_lvl;
    int                errors;
    int                n_checks;
    logic [7:0]        ofs [5];
    logic [15:0]       first_val;
    logic [15:0]       m;
    logic [15:0]       bdt_raw;
    logic [15:0]       ctrl2_raw;
    logic [15:0]       ccen_raw;
    logic [15:0]       ccm1_raw;
    logic [15:0]       ccm2_raw;

    tcwl_top #(.NUM_CHANNELS(4)) dut (
        .ref_clk_i                (ref_clk_i),
        .rst_i                    (rst_i),
        .addr_i                   (addr_i),
        .wdata_i                  (wdata_i),
        .wr_i                     (wr_i),
        .rd_i                     (rd_i),
        .rdata_o                  (rdata_o),
        .dead_time_setting_o      (dead_time),
        .protect_level_o          (lvl_o),
        .main_output_enable_o     (main_en),
        .channel_output_enable_o  (chan_en),
        .chan_offstate_drive_o    (offdrv),
        .chan_idle_level_o        (idle_lvl),
        .break_deadtime_control_o (bdt_raw),
        .timer_control_two_o      (ctrl2_raw),
        .channel_enable_register_o(ccen_raw),
        .channel_mode_one_o       (ccm1_raw),
        .channel_mode_two_o       (ccm2_raw)
    );

    initial begin
        ref_clk_i = 1'b0;
        forever #4 ref_clk_i = ~ref_clk_i;
    end

    task automatic final_report();
        $display("checks=%0d mismatches=%0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic do_reset();
        rst_i <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        rst_i <= 1'b0;
    endtask

    // Upper half carries ones so that ignored bits are exercised
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= {16'hffff, d};
        @(posedge ref_clk_i);
        wr_i    <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge ref_clk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge ref_clk_i);
        rd_i   <= 1'b0;
        #1;
        chk(rdata_o, {16'h0000, exp});
    endtask

    // Bits that a write may not change at a given level
    function automatic logic [15:0] lock_of(input int r, input logic [1:0] l);
        case (r)
            0: lock_of = 16'h0300 | ((l >= 2'h1) ? 16'h70ff : 16'h0000)
                                  | ((l >= 2'h2) ? 16'h0c00 : 16'h0000);
            1: lock_of = (l >= 2'h1) ? 16'h7f00 : 16'h0000;
            2: lock_of = (l >= 2'h2) ? 16'h2aaa : 16'h0000;
            default: lock_of = (l == 2'h3) ? 16'h7878 : 16'h0000;
        endcase
    endfunction

    // Guard against a hung run
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        errors++;
        final_report();
    end

    initial begin
        ofs = '{OFS_BREAK_DEADTIME_CONTROL, OFS_TIMER_CONTROL_TWO,
                OFS_CHANNEL_ENABLE_REGISTER, OFS_CHANNEL_MODE_ONE, OFS_CHANNEL_MODE_TWO};
        errors   = 0;
        n_checks = 0;
        wr_i    <= 1'b0;
        rd_i    <= 1'b0;
        addr_i  <= 8'h00;
        wdata_i <= 32'h0000_0000;
        do_reset();
        for (int r = 0; r < 5; r++) begin
            rd(ofs[r], 16'h0000);
        end
        rd(8'h08, 16'h0000);
        @(posedge ref_clk_i);
        #1;
        chk(rdata_o, 32'h0000_0000);
        $display("test reset values done");

        for (int l = 0; l < 4; l++) begin
            do_reset();
            for (int r = 1; r < 5; r++) begin
                wr(ofs[r], 16'ha5a5);
            end
            first_val = (16'ha5a5 & ~16'h0300) | (16'(l) << 8);
            wr(ofs[0], first_val);
            chk({30'h0, lvl_o}, 32'(l));
            for (int r = 0; r < 5; r++) begin
                wr(ofs[r], 16'h5a5a);
            end
            for (int r = 0; r < 5; r++) begin
                m = lock_of((r > 3) ? 3 : r, 2'(l));
                rd(ofs[r], (16'h5a5a & ~m) | (((r == 0) ? first_val : 16'ha5a5) & m));
            end
            chk({16'h0, ccm1_raw}, {16'h0, (16'h5a5a & ~m) | (16'ha5a5 & m)});
            chk({16'h0, ccm2_raw}, {16'h0, (16'h5a5a & ~m) | (16'ha5a5 & m)});
            $display("test protect level %0d done", l);
        end

        do_reset();
        wr(OFS_CHANNEL_ENABLE_REGISTER, 16'h0011);
        wr(OFS_TIMER_CONTROL_TWO, 16'h1100);
        wr(OFS_BREAK_DEADTIME_CONTROL, 16'h88a7);
        chk({28'h0, chan_en}, 32'h3);
        chk({31'h0, main_en}, 32'h1);
        chk({28'h0, offdrv}, 32'hc);
        chk({24'h0, dead_time}, 32'ha7);
        chk({28'h0, idle_lvl}, 32'h5);
        chk({16'h0, bdt_raw}, 32'h88a7);
        chk({16'h0, ctrl2_raw}, 32'h1100);
        chk({16'h0, ccen_raw}, 32'h0011);
        wr(OFS_BREAK_DEADTIME_CONTROL, 16'h0400);
        chk({28'h0, offdrv}, 32'hf);
        chk({31'h0, main_en}, 32'h0);
        wr(OFS_BREAK_DEADTIME_CONTROL, 16'h0000);
        chk({28'h0, offdrv}, 32'h0);
        wr(8'h08, 16'hffff);
        rd(8'h08, 16'h0000);
        $display("test off-state selection done");
        final_report();
    end
endmodule
